// file: bias_ctrl_defines.vh
`ifndef BIAS_CTRL_DEFINES_VH
`define BIAS_CTRL_DEFINES_VH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define ADDR_CTRL0      8'h80
`define ADDR_TABLE1_ROW 8'h81
`define ADDR_TABLE2_ROW 8'h82
`define ADDR_GEN1_CODE  8'h83
`define ADDR_GEN2_CODE  8'h84
`define ADDR_PATH_RANGE 8'h85
`define ADDR_WRITE_GATE 8'h86
`define ADDR_CONV_RES   8'h87
`define ADDR_RSV_LO     8'h88
`define ADDR_RSV_HI     8'h8f
// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_GEN2_POL    7
`define BIT_GEN1_POL    6
`define BIT_PERSIST     5
`define BIT_GEN2_MAN    7
`define BIT_TABLE2_MAN  6
`define BIT_GEN1_MAN    5
`define BIT_TABLE1_MAN  4
`define BIT_WEL         7
`define ROW_MASK        8'h3f
`define CTRL0_MASK      8'he0
`define FLD_RANGE1      1:0
`define FLD_RANGE2      3:2
`define RES_PAD         2'b00
`define GATE_PAD        7'h00
`define RANGE_ZERO      2'b00
// ----------------------------------------
// table bases and codes
// ----------------------------------------
`define TABLE1_BASE     9'h090
`define TABLE2_BASE     9'h0d0
`define WEL_SET_CODE    8'h80
`define WEL_CLR_CODE    8'h00
`define BYTE_ZERO       8'h00
`endif

// file: bias_ctrl_direct_access_regs.v
`timescale 1ns/1ps
`default_nettype none
`include "bias_ctrl_defines.vh"

// Operation
// [R01] Byte 81h holds the first table row override, kept volatile or also nonvolatile per the persistence select.
// [R02] Byte 82h holds the second table row override, with the same persistence handling.
// [R03] Byte 83h holds the first generator direct code, with the same persistence handling.
// [R04] The second generator sources current when its polarity bit is 0 and sinks when it is 1.
// [R05] With bit 4 of byte 85h set the first table is indexed by the override bits, otherwise by the converter result.
// [R06] The first table row address is the six bit index added to base 90h.
// [R07] With bit 6 of byte 85h set the second table is indexed by its override bits, otherwise by the converter result.
// [R08] The second table row address is the six bit index added to base D0h.
// [R09] Bytes 88h through 8Fh are reserved and hold no registers.
// [R10] With the first generator manual bit set its converter takes byte 83h, otherwise the selected first table row.
// [R11] The write enable latch resets clear, 80h to byte 86h sets it, 00h clears it, and while clear other writes abort unacknowledged.
// [R12] With persistence select 0 writes to bytes 81h-84h stay volatile; with 1 they are also sent to nonvolatile storage.
// [R13] Reserved bits are written as zero by the host and read back as zero here.
// [R14] Reserved addresses read zero and writes to them are dropped.
module bias_ctrl_direct_access_regs #(
  parameter ROW_W = 6
) (
  // clock and reset
  input  wire         clk_in,
  input  wire         nrst_in,
  // register port
  input  wire [7:0]   addr_in,
  input  wire [7:0]   wdata_in,
  input  wire         wr_in,
  input  wire         rd_in,
  output reg  [7:0]   rdata_out,
  output wire         wr_ack_out,
  // converter and table interface
  input  wire [ROW_W-1:0] converter_result_code_in,
  input  wire [7:0]   table1_row_data_in,
  input  wire [7:0]   table2_row_data_in,
  output reg  [8:0]   table1_row_addr_out,
  output reg  [8:0]   table2_row_addr_out,
  output reg  [7:0]   first_output_converter_code_out,
  output reg  [7:0]   second_output_converter_code_out,
  // analog config
  output reg          gen1_polarity_out,
  output reg          gen2_polarity_out,
  output reg  [1:0]   gen1_range_select_out,
  output reg  [1:0]   gen2_range_select_out,
  // nonvolatile copy request
  output reg          nv_store_out,
  output reg  [7:0]   nv_addr_out,
  output reg  [7:0]   nv_data_out
);

  // ----------------------------------------
  // storage
  // ----------------------------------------
  reg [7:0] ctrl0;
  reg [7:0] table1_row_override;
  reg [7:0] table2_row_index_reg;
  reg [7:0] gen1_direct_code_reg;
  reg [7:0] gen2_direct_code_reg;
  reg [7:0] direct_path_and_range_reg;
  reg       write_enable_latch;
  reg [7:0] converter_result_reg;

  // ----------------------------------------
  // next values
  // ----------------------------------------
  reg [7:0] next_ctrl0;
  reg [7:0] next_table1_row_override;
  reg [7:0] next_table2_row_index_reg;
  reg [7:0] next_gen1_direct_code_reg;
  reg [7:0] next_gen2_direct_code_reg;
  reg [7:0] next_path_range;
  reg       next_write_enable_latch;
  reg       next_nv_store;
  reg [7:0] next_nv_addr;
  reg [7:0] next_nv_data;
  reg [7:0] next_rdata;
  reg [8:0] next_table1_row_addr;
  reg [8:0] next_table2_row_addr;
  reg [7:0] next_first_output_converter_code;
  reg [7:0] next_second_output_converter_code;

  wire gate_ok = write_enable_latch;
  wire wr_gate = wr_in && (addr_in == `ADDR_WRITE_GATE);
  wire wr_any  = wr_in && gate_ok && !wr_gate;
  wire persist_sel = ctrl0[`BIT_PERSIST];
  wire is_volatile_group = (addr_in >= `ADDR_TABLE1_ROW) &&
                           (addr_in <= `ADDR_GEN2_CODE);

  // latch write itself always accepted; others need the latch
  assign wr_ack_out = wr_in && (gate_ok || wr_gate); // [R11]

  function [8:0] row_addr;
    input [8:0]       base;
    input             manual;
    input [7:0]       override;
    input [ROW_W-1:0] conv;
    reg   [ROW_W-1:0] idx;
    begin
      idx = manual ? override[ROW_W-1:0] : conv;
      row_addr = base + {3'h0, idx};
    end
  endfunction

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always @* begin
    next_ctrl0                = ctrl0;
    next_table1_row_override  = table1_row_override;
    next_table2_row_index_reg = table2_row_index_reg;
    next_gen1_direct_code_reg = gen1_direct_code_reg;
    next_gen2_direct_code_reg = gen2_direct_code_reg;
    next_path_range           = direct_path_and_range_reg;
    if (wr_any) begin
      case (addr_in)
        `ADDR_CTRL0: begin
          next_ctrl0 = wdata_in & `CTRL0_MASK;
        end
        `ADDR_TABLE1_ROW: begin
          next_table1_row_override = wdata_in & `ROW_MASK; // [R01]
        end
        `ADDR_TABLE2_ROW: begin
          next_table2_row_index_reg = wdata_in & `ROW_MASK; // [R02]
        end
        `ADDR_GEN1_CODE: begin
          next_gen1_direct_code_reg = wdata_in; // [R03]
        end
        `ADDR_GEN2_CODE: begin
          next_gen2_direct_code_reg = wdata_in;
        end
        `ADDR_PATH_RANGE: begin
          next_path_range = wdata_in;
        end
        default: begin
          // reserved and read-only bytes drop writes
          next_ctrl0 = ctrl0; // [R09] [R14]
        end
      endcase
    end
  end

  // ----------------------------------------
  // write enable latch
  // ----------------------------------------
  // only the two set and clear codes move the latch
  always @* begin
    next_write_enable_latch = write_enable_latch;
    if (wr_gate && (wdata_in == `WEL_SET_CODE)) begin
      next_write_enable_latch = 1'b1; // [R11]
    end else if (wr_gate && (wdata_in == `WEL_CLR_CODE)) begin
      next_write_enable_latch = 1'b0; // [R11]
    end
  end

  // ----------------------------------------
  // nonvolatile copy request
  // ----------------------------------------
  // only bytes 81h-84h follow persistence; address and data hold
  wire nv_req = wr_any && is_volatile_group && persist_sel;

  always @* begin
    next_nv_store = nv_req; // [R12]
    next_nv_addr  = nv_addr_out;
    next_nv_data  = nv_data_out;
    if (nv_req) begin
      next_nv_addr = addr_in;
      if (addr_in <= `ADDR_TABLE2_ROW) begin
        next_nv_data = wdata_in & `ROW_MASK; // [R13]
      end else begin
        next_nv_data = wdata_in;
      end
    end
  end

  // ----------------------------------------
  // register state
  // ----------------------------------------
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      ctrl0                     <= `BYTE_ZERO;
      table1_row_override       <= `BYTE_ZERO;
      table2_row_index_reg      <= `BYTE_ZERO;
      gen1_direct_code_reg      <= `BYTE_ZERO;
      gen2_direct_code_reg      <= `BYTE_ZERO;
      direct_path_and_range_reg <= `BYTE_ZERO;
      write_enable_latch        <= 1'b0; // [R11]
      converter_result_reg      <= `BYTE_ZERO;
      nv_store_out              <= 1'b0;
      nv_addr_out               <= `BYTE_ZERO;
      nv_data_out               <= `BYTE_ZERO;
    end else begin
      ctrl0                     <= next_ctrl0;
      table1_row_override       <= next_table1_row_override;
      table2_row_index_reg      <= next_table2_row_index_reg;
      gen1_direct_code_reg      <= next_gen1_direct_code_reg;
      gen2_direct_code_reg      <= next_gen2_direct_code_reg;
      direct_path_and_range_reg <= next_path_range;
      write_enable_latch        <= next_write_enable_latch;
      // result byte one cycle late; reserved low bits kept zero
      converter_result_reg <= {converter_result_code_in, `RES_PAD}; // [R13]
      nv_store_out              <= next_nv_store;
      nv_addr_out               <= next_nv_addr;
      nv_data_out               <= next_nv_data;
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always @* begin
    next_rdata = `BYTE_ZERO;
    if (rd_in) begin
      case (addr_in)
        `ADDR_CTRL0: begin
          next_rdata = ctrl0;
        end
        `ADDR_TABLE1_ROW: begin
          next_rdata = table1_row_override;
        end
        `ADDR_TABLE2_ROW: begin
          next_rdata = table2_row_index_reg;
        end
        `ADDR_GEN1_CODE: begin
          next_rdata = gen1_direct_code_reg;
        end
        `ADDR_GEN2_CODE: begin
          next_rdata = gen2_direct_code_reg;
        end
        `ADDR_PATH_RANGE: begin
          next_rdata = direct_path_and_range_reg;
        end
        `ADDR_WRITE_GATE: begin
          next_rdata = {write_enable_latch, `GATE_PAD}; // [R13]
        end
        `ADDR_CONV_RES: begin
          next_rdata = converter_result_reg;
        end
        default: begin
          next_rdata = `BYTE_ZERO; // [R09] [R14]
        end
      endcase
    end
  end

  // data is zero outside the read cycle so stale bytes never leak
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      rdata_out <= `BYTE_ZERO;
    end else begin
      rdata_out <= next_rdata;
    end
  end

  // ----------------------------------------
  // data path steering
  // ----------------------------------------
  always @* begin
    next_table1_row_addr = row_addr(`TABLE1_BASE,
      direct_path_and_range_reg[`BIT_TABLE1_MAN],
      table1_row_override, converter_result_code_in); // [R05] [R06]
    next_table2_row_addr = row_addr(`TABLE2_BASE,
      direct_path_and_range_reg[`BIT_TABLE2_MAN],
      table2_row_index_reg, converter_result_code_in); // [R07] [R08]
    if (direct_path_and_range_reg[`BIT_GEN1_MAN]) begin
      next_first_output_converter_code = gen1_direct_code_reg; // [R10]
    end else begin
      next_first_output_converter_code = table1_row_data_in; // [R10]
    end
    if (direct_path_and_range_reg[`BIT_GEN2_MAN]) begin
      next_second_output_converter_code = gen2_direct_code_reg;
    end else begin
      next_second_output_converter_code = table2_row_data_in;
    end
  end

  // registered outputs add one cycle of latency on mode changes
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      table1_row_addr_out   <= `TABLE1_BASE;
      table2_row_addr_out   <= `TABLE2_BASE;
      first_output_converter_code_out         <= `BYTE_ZERO;
      second_output_converter_code_out         <= `BYTE_ZERO;
      gen1_polarity_out     <= 1'b0;
      gen2_polarity_out     <= 1'b0;
      gen1_range_select_out <= `RANGE_ZERO;
      gen2_range_select_out <= `RANGE_ZERO;
    end else begin
      table1_row_addr_out   <= next_table1_row_addr;
      table2_row_addr_out   <= next_table2_row_addr;
      first_output_converter_code_out         <= next_first_output_converter_code;
      second_output_converter_code_out         <= next_second_output_converter_code;
      gen1_polarity_out     <= ctrl0[`BIT_GEN1_POL];
      gen2_polarity_out     <= ctrl0[`BIT_GEN2_POL]; // [R04]
      gen1_range_select_out <= direct_path_and_range_reg[`FLD_RANGE1];
      gen2_range_select_out <= direct_path_and_range_reg[`FLD_RANGE2];
    end
  end

endmodule // bias_ctrl_direct_access_regs
`default_nettype wire

// file: bias_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module bias_ctrl_chk (
  // register port
  input wire logic       clk_in,
  input wire logic       nrst_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic       wr_ack_out,
  // steering and copy
  input wire logic [8:0] table1_row_addr_out,
  input wire logic [8:0] table2_row_addr_out,
  input wire logic       nv_store_out
);
  // ----------------------------------------
  // shadow of the write gate
  // ----------------------------------------
  logic gate;
  wire  w86  = wr_in && addr_in == 8'h86;
  wire  rsv  = rd_in && addr_in[7:3] == 5'h11;
  wire  rrow = rd_in && (addr_in == 8'h81 || addr_in == 8'h82);
  // the latch shows only in the ack and in reads of 86h, so track it from the writes seen
  always_ff @(posedge clk_in)
    if (!nrst_in) gate <= 1'b0;
    else if (w86 && wdata_in == 8'h80) gate <= 1'b1;
    else if (w86 && wdata_in == 8'h00) gate <= 1'b0;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  AST_GATE_OPEN: assert property (w86 |-> wr_ack_out)
    else $error("gate write not acked");
  AST_GATE_SHUT: assert property (wr_in && !gate && !w86
    |-> !wr_ack_out) else $error("write acked while gate shut");
  AST_GATE_SET: assert property (wr_in && gate |-> wr_ack_out)
    else $error("write refused while gate open");
  AST_RSV_READ: assert property (rsv |=> rdata_out == 8'h00)
    else $error("reserved address read nonzero");
  AST_ROW_RSV: assert property (rrow |=> rdata_out[7:6] == 2'b00)
    else $error("row override upper bits set");
  AST_STAT_RSV: assert property (rd_in && addr_in == 8'h87
    |=> rdata_out[1:0] == 2'b00) else $error("status low bits set");
  AST_T1_SPAN: assert property (table1_row_addr_out inside
    {[9'h090:9'h0cf]}) else $error("table1 row outside its table");
  AST_T2_SPAN: assert property (table2_row_addr_out inside
    {[9'h0d0:9'h10f]}) else $error("table2 row outside its table");
  AST_NV_CAUSE: assert property (nv_store_out |-> $past(wr_ack_out) &&
    $past(addr_in) inside {[8'h81:8'h84]}) else $error("stray store");
  cover property (wr_in && !gate && !w86);
  cover property (nv_store_out);
  cover property (rsv);
endmodule // bias_ctrl_chk
bind bias_ctrl_direct_access_regs bias_ctrl_chk chk_u (
  .clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .wr_ack_out(wr_ack_out),
  .table1_row_addr_out(table1_row_addr_out),
  .table2_row_addr_out(table2_row_addr_out), .nv_store_out(nv_store_out));
`default_nettype wire

// file: bias_ctrl_direct_access_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module bias_ctrl_direct_access_regs_test;
  logic       clk_in = 1'b0;
  logic       nrst_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic       wr_in = 1'b0;
  logic       rd_in = 1'b0;
  logic [5:0] conv = 6'h15;
  logic [7:0] row1 = 8'h3c;
  logic [7:0] row2 = 8'hc3;
  wire  [7:0] rdata_out, nv_addr_out, first_output_converter_code_out;
  wire  [7:0] second_output_converter_code_out, nv_data_out;
  wire  [8:0] t1_addr, t2_addr;
  wire  [1:0] rng1, rng2;
  wire        wr_ack_out, gen2_pol, gen1_pol, nv_store_out;
  int         n_errors = 0;
  int         compares = 0;
  int         cycles = 0;
  bias_ctrl_direct_access_regs dut_u (
    .clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .wr_ack_out(wr_ack_out),
    .converter_result_code_in(conv), .table1_row_data_in(row1),
    .table2_row_data_in(row2), .table1_row_addr_out(t1_addr),
    .table2_row_addr_out(t2_addr), .first_output_converter_code_out(first_output_converter_code_out),
    .second_output_converter_code_out(second_output_converter_code_out), .gen1_polarity_out(gen1_pol),
    .gen2_polarity_out(gen2_pol),
    .gen1_range_select_out(rng1), .gen2_range_select_out(rng2),
    .nv_store_out(nv_store_out), .nv_addr_out(nv_addr_out),
    .nv_data_out(nv_data_out));
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic k);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    #1 chk(wr_ack_out, k);
    @(posedge clk_in);
    wr_in <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk(rdata_out, exp);
  endtask
  // steering is registered twice, so let it land
  task automatic settle;
    repeat (3) @(posedge clk_in);
    #1;
  endtask
  task automatic wrap_up;
    $display("n_errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial forever #2 clk_in = ~clk_in;
  // a hung handshake must still reach the verdict
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      wrap_up;
    end
  end
  initial begin
    repeat (8) @(posedge clk_in);
    nrst_in <= 1'b1;
    #1 chk(gen2_pol, 1'b0);
    rd(8'h86, 8'h00);
    wr(8'h81, 8'h05, 1'b0);
    rd(8'h81, 8'h00);
    wr(8'h86, 8'h80, 1'b1);
    rd(8'h86, 8'h80);
    wr(8'h81, 8'h3f, 1'b1);
    rd(8'h81, 8'h3f);
    wr(8'h82, 8'h3f, 1'b1);
    rd(8'h82, 8'h3f);
    wr(8'h83, 8'ha5, 1'b1);
    chk(nv_store_out, 1'b0);
    rd(8'h83, 8'ha5);
    wr(8'h85, 8'h7e, 1'b1);
    settle;
    chk(t1_addr, 9'h0cf);
    chk(t2_addr, 9'h10f);
    chk(first_output_converter_code_out, 8'ha5);
    chk(second_output_converter_code_out, 8'hc3);
    chk(rng1, 2'b10);
    chk(rng2, 2'b11);
    wr(8'h85, 8'h00, 1'b1);
    settle;
    chk(t1_addr, 9'h0a5);
    chk(t2_addr, 9'h0e5);
    chk(first_output_converter_code_out, 8'h3c);
    wr(8'h80, 8'ha0, 1'b1);
    settle;
    chk(gen2_pol, 1'b1);
    chk(gen1_pol, 1'b0);
    wr(8'h84, 8'h11, 1'b1);
    chk(nv_store_out, 1'b1);
    chk(nv_addr_out, 8'h84);
    chk(nv_data_out, 8'h11);
    wr(8'h85, 8'h80, 1'b1);
    settle;
    chk(second_output_converter_code_out, 8'h11);
    wr(8'h8a, 8'h55, 1'b1);
    chk(nv_store_out, 1'b0);
    for (int a = 8'h88; a <= 8'h8f; a++) rd(a[7:0], 8'h00);
    rd(8'h87, 8'h54);
    wr(8'h86, 8'h00, 1'b1);
    wr(8'h84, 8'h77, 1'b0);
    rd(8'h84, 8'h11);
    wrap_up;
  end
endmodule // bias_ctrl_direct_access_regs_test
`default_nettype wire
